// file: design/spt_pkg.sv
// shared constants, carriers and helpers for the service panel test control
package spt_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses) and field layouts
  // ----------------------------------------------------------------
  localparam int unsigned    ADDR_W     = 12;
  localparam int unsigned    DATA_W     = 32;
  localparam logic [11:0]    OFF_CTRL   = 12'h000;
  localparam logic [11:0]    OFF_PANEL  = 12'h004;
  localparam logic [11:0]    OFF_CMD    = 12'h008;
  localparam logic [11:0]    OFF_STAT   = 12'h00c;
  localparam logic [11:0]    OFF_MASK   = 12'h010;
  localparam logic [11:0]    OFF_INFO   = 12'h014;
  localparam int unsigned    CMD_STORE  = 4;
  localparam int unsigned    CMD_FETCH  = 5;
  localparam int unsigned    NUM_EV     = 5;
  localparam int unsigned    EV_STORE   = 0;
  localparam int unsigned    EV_FETCH   = 1;
  localparam int unsigned    EV_LOGOUT  = 2;
  localparam int unsigned    EV_HALT    = 3;
  localparam int unsigned    EV_SIMWR   = 4;
  localparam logic [4:0]     CTRL_RST   = 5'h00;
  localparam logic [7:0]     PANEL_RST  = 8'h00;
  localparam logic [4:0]     MASK_RST   = 5'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {logic sim_iface; logic sim_stor; logic logout_on_fault_switch;
                         logic lamp_check_switch; logic test_mode;} spt_ctrl_type;
  typedef struct packed {logic clr_int; logic halt_io; logic test_io; logic start_io;} spt_cmd_type;
  typedef struct packed {logic sel; logic wr; logic rd; logic [7:0] data;} spt_chio_type;
  typedef struct packed {logic valid; logic [7:0] data;} spt_byte_type;
  typedef struct packed {logic req; logic write; logic [7:0] data;} spt_stor_req_type;
  typedef struct packed {logic ack; logic [7:0] data;} spt_stor_rsp_type;
  typedef struct packed {logic [8:0] a_lamps; logic [8:0] b_lamps; logic [4:0] status_lamps;
                         logic [4:0] ctrl_lamps; logic [3:0] state_lamps;} spt_lamp_type;
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_STORE = 4'h2, ST_FETCH = 4'h4, ST_DONE = 4'h8} spt_state_type;

  // odd parity bit for a data byte
  function automatic logic spt_par(input logic [7:0] d);
    return ~(^d);
  endfunction

endpackage

// file: design/spt_sim_iface.sv
// simulated interface register and bus-out / bus-in latches
`timescale 1ns/1ns
`default_nettype none
module spt_sim_iface (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clr,
  input  wire logic                  sim_en,
  input  wire spt_pkg::spt_chio_type chan_io,
  input  wire spt_pkg::spt_byte_type io_in,
  output var  spt_pkg::spt_byte_type line_out,
  output var  spt_pkg::spt_byte_type bus_in,
  output var  logic [7:0]            sir,
  output var  logic                  sir_loaded
);
  import spt_pkg::*;

  logic [7:0] bout_reg;
  logic       loop_reg;
  logic       wr_reg;

  // bus-out latches; the byte also drives the line unless blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bout_reg <= 8'h00;
      loop_reg <= 1'b0;
      wr_reg   <= 1'b0;
      line_out <= '0;
    end else if (clr) begin
      bout_reg <= 8'h00;
      loop_reg <= 1'b0;
      wr_reg   <= 1'b0;
      line_out <= '0;
    end else begin
      if (chan_io.sel || chan_io.wr) begin
        bout_reg <= chan_io.data;                          // see RL15
      end
      loop_reg <= sim_en && chan_io.sel;
      wr_reg   <= sim_en && chan_io.wr;
      line_out <= '{valid: !sim_en && (chan_io.sel || chan_io.wr), data: chan_io.data};  // see RL13
    end
  end

  // simulated register loads only on a valid write byte, else holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sir        <= 8'h00;
      sir_loaded <= 1'b0;
    end else if (clr) begin
      sir        <= 8'h00;
      sir_loaded <= 1'b0;
    end else begin
      sir_loaded <= wr_reg;
      if (wr_reg) begin
        sir <= bout_reg;                                   // see RL16 see RL18
      end
    end
  end

  // bus-in latches: looped address, static register, or the real line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_in <= '0;
    end else if (clr) begin
      bus_in <= '0;
    end else if (!sim_en) begin
      bus_in <= io_in;                                     // see RL14
    end else if (loop_reg) begin
      bus_in <= '{valid: 1'b1, data: bout_reg};            // see RL15
    end else if (chan_io.rd) begin
      bus_in <= '{valid: 1'b1, data: sir};                 // see RL17
    end else begin
      bus_in <= '0;
    end
  end

  property p_sir_hold;
    @(posedge pclk) disable iff (!presetn)
    (!wr_reg && !clr) |=> $stable(sir);
  endproperty
  a_sir_hold: assert property (p_sir_hold) else $error("simulated register changed without a write byte"); // see RL18

  property p_read_static;
    @(posedge pclk) disable iff (!presetn)
    (sim_en && chan_io.rd && !loop_reg && !clr) |=> (bus_in.valid && bus_in.data == $past(sir));
  endproperty
  a_read_static: assert property (p_read_static) else $error("simulated read did not return register"); // see RL17

endmodule
`default_nettype wire

// file: design/spt_lamp_drv.sv
// panel indicator drivers with lamp test
`timescale 1ns/1ns
`default_nettype none
module spt_lamp_drv (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 lamp_test,
  input  wire logic [7:0]           a_byte,
  input  wire logic [7:0]           b_byte,
  input  wire logic [4:0]           status,
  input  wire logic [4:0]           ctrl,
  input  wire logic [3:0]           state,
  output var  spt_pkg::spt_lamp_type lamps
);
  import spt_pkg::*;

  // lamps follow live state in both modes; lamp test forces all but data bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamps <= '0;
    end else if (lamp_test) begin
      lamps <= '{a_lamps: {1'b1, a_byte}, b_lamps: {1'b1, b_byte},   // see RL4
                 status_lamps: '1, ctrl_lamps: '1, state_lamps: '1};
    end else begin
      lamps <= '{a_lamps: {spt_par(a_byte), a_byte}, b_lamps: {spt_par(b_byte), b_byte},  // see RL1
                 status_lamps: status, ctrl_lamps: ctrl, state_lamps: state};
    end
  end

  property p_lamp_test;
    @(posedge pclk) disable iff (!presetn)
    lamp_test |=> (lamps.a_lamps[8] && lamps.b_lamps[8] && &lamps.status_lamps && &lamps.state_lamps
                   && lamps.a_lamps[7:0] == $past(a_byte));
  endproperty
  a_lamp_test: assert property (p_lamp_test) else $error("lamp test pattern wrong"); // see RL4

endmodule
`default_nettype wire

// file: design/spt_service_panel.sv
// service panel test control top: apb registers, mode gating, store/fetch sequencer
//
// Overview of operation
// RL1: automatic mode runs on line under processor control; all lamps stay live.
// RL2: automatic mode ignores panel switches except logout-on-fault and lamp check.
// RL3: logout-on-fault on in automatic mode starts logout on machine check.
// RL4: lamp check lights every lamp except register data bits; parity lamps lit.
// RL5: test mode runs off line; panel switches and lamps decide the operations.
// RL6: test mode panel issues start, test, halt I/O and clear interrupt.
// RL7: no panel initial program load, test channel, fault-locating, diagnostic or logout.
// RL8: test mode with logout-on-fault halts on machine check or data check.
// RL9: storage simulation answers internally and blocks both storage interface directions.
// RL10: without storage simulation main storage is used and lines are unblocked.
// RL11: manual store loads A-register from panel byte; memory written only unsimulated.
// RL12: manual fetch or start-I/O write fetches from panel bytes or main storage.
// RL13: interface simulation answers internally and blocks both I/O interface directions.
// RL14: without interface simulation signals pass normally to control units.
// RL15: device selection loops address through bus-out latches into bus-in latches.
// RL16: simulated writes capture each bus-out byte and keep the last one.
// RL17: simulated reads repeatedly return the static simulated register to B-register.
// RL18: simulated register loads only on a valid write byte, else holds.
// RL19: power-on reset clears channel logic until power complete is established.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module spt_service_panel (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [11:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic                      power_complete,
  input  wire logic                      mach_chk,
  input  wire logic                      data_chk,
  input  wire spt_pkg::spt_cmd_type      cpu_cmd,
  input  wire logic                      fetch_req,
  input  wire spt_pkg::spt_stor_rsp_type stor_rsp,
  output var  spt_pkg::spt_stor_req_type stor_req,
  output var  logic                      stor_block,
  input  wire spt_pkg::spt_chio_type     chan_io,
  input  wire spt_pkg::spt_byte_type     io_in,
  output var  spt_pkg::spt_byte_type     io_out,
  output var  logic                      io_block,
  output var  spt_pkg::spt_byte_type     bus_in,
  output var  spt_pkg::spt_cmd_type      chan_cmd,
  output var  spt_pkg::spt_byte_type     fetch_data,
  output var  logic                      logout_start,
  output var  logic                      chan_halt,
  output var  spt_pkg::spt_lamp_type     lamps,
  output var  logic                      irq
);
  import spt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic               pc_meta_reg;
  logic               pc_sync_reg;
  logic               clr;
  spt_ctrl_type       ctrl_reg;
  logic [7:0]         panel_byte_switches;
  logic [NUM_EV-1:0]  status_reg;
  logic [NUM_EV-1:0]  status_next;
  logic [NUM_EV-1:0]  mask_reg;
  logic [NUM_EV-1:0]  ev;
  logic [NUM_EV-1:0]  w1c;
  logic [31:0]        rdata_next;
  logic               unmapped;
  logic               wr_en;
  logic               cmd_wr;
  logic               test;
  logic               eff_sim_stor;
  logic               eff_sim_iface;
  logic               man_store;
  logic               man_fetch;
  logic               logout_next;
  logic               halt_set;
  spt_state_type      state_reg;
  logic               op_fetch_reg;
  logic [7:0]         a_reg;
  logic [7:0]         sir;
  logic               sir_loaded;

  // ----------------------------------------------------------------
  // power-complete synchroniser and channel clear
  // ----------------------------------------------------------------
  // the pin is asynchronous, so only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_meta_reg <= 1'b0;
      pc_sync_reg <= 1'b0;
    end else begin
      pc_meta_reg <= power_complete;
      pc_sync_reg <= pc_meta_reg;
    end
  end

  // logic stays cleared until supply is reported complete
  assign clr = !pc_sync_reg;                               // see RL19

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  assign wr_en  = psel && penable && pready && pwrite;
  assign cmd_wr = wr_en && (paddr == OFF_CMD);
  assign w1c    = (wr_en && paddr == OFF_STAT) ? pwdata[NUM_EV-1:0] : '0;

  // read mux; answered data is latched in the setup cycle
  always_comb begin
    rdata_next = 32'h0000_0000;
    unmapped   = 1'b0;
    case (paddr)
      OFF_CTRL:  rdata_next[4:0] = ctrl_reg;
      OFF_PANEL: rdata_next[7:0] = panel_byte_switches;
      OFF_CMD:   rdata_next      = 32'h0000_0000;
      OFF_STAT:  rdata_next[NUM_EV-1:0] = status_reg;
      OFF_MASK:  rdata_next[NUM_EV-1:0] = mask_reg;
      OFF_INFO:  rdata_next[27:0] = {state_reg, sir, a_reg, bus_in.data};
      default:   unmapped = 1'b1;
    endcase
  end

  // pready rises for exactly the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // configuration registers; writes are accepted in either mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg            <= spt_ctrl_type'(CTRL_RST);
      panel_byte_switches <= PANEL_RST;
      mask_reg            <= MASK_RST;
    end else if (clr) begin
      ctrl_reg            <= spt_ctrl_type'(CTRL_RST);
      panel_byte_switches <= PANEL_RST;
      mask_reg            <= MASK_RST;
    end else if (wr_en) begin
      if (paddr == OFF_CTRL) begin
        ctrl_reg <= spt_ctrl_type'(pwdata[4:0]);
      end
      if (paddr == OFF_PANEL) begin
        panel_byte_switches <= pwdata[7:0];
      end
      if (paddr == OFF_MASK) begin
        mask_reg <= pwdata[NUM_EV-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // mode gating
  // ----------------------------------------------------------------
  // simulation selects and commands only count in test mode
  assign test          = ctrl_reg.test_mode;                           // see RL5
  assign eff_sim_stor  = test && ctrl_reg.sim_stor;                    // see RL2
  assign eff_sim_iface = test && ctrl_reg.sim_iface;                   // see RL2
  assign man_store     = test && cmd_wr && pwdata[CMD_STORE];          // see RL2
  assign man_fetch     = test && cmd_wr && pwdata[CMD_FETCH];
  // logout only in automatic mode; test mode has no logout path
  assign logout_next   = !test && ctrl_reg.logout_on_fault_switch && mach_chk;           // see RL3 see RL7
  assign halt_set      = test && ctrl_reg.logout_on_fault_switch && (mach_chk || data_chk); // see RL8

  // channel command source: processor on line, panel off line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_cmd     <= '0;
      logout_start <= 1'b0;
      stor_block   <= 1'b0;
      io_block     <= 1'b0;
    end else if (clr) begin
      chan_cmd     <= '0;
      logout_start <= 1'b0;
      stor_block   <= 1'b0;
      io_block     <= 1'b0;
    end else begin
      chan_cmd     <= test ? (cmd_wr ? spt_cmd_type'(pwdata[3:0]) : '0) : cpu_cmd;  // see RL1 see RL6
      logout_start <= logout_next;
      stor_block   <= eff_sim_stor;                        // see RL9 see RL10
      io_block     <= eff_sim_iface;                       // see RL13
    end
  end

  // ----------------------------------------------------------------
  // store / fetch sequencer
  // ----------------------------------------------------------------
  // a halted channel takes no new cycle; fetch_req is the start-I/O write fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      op_fetch_reg <= 1'b0;
      a_reg        <= 8'h00;
      stor_req     <= '0;
      fetch_data   <= '0;
    end else if (clr) begin
      state_reg    <= ST_IDLE;
      op_fetch_reg <= 1'b0;
      a_reg        <= 8'h00;
      stor_req     <= '0;
      fetch_data   <= '0;
    end else begin
      fetch_data <= '0;
      case (state_reg)
        ST_IDLE: begin
          if (!chan_halt && man_store) begin
            a_reg        <= panel_byte_switches;           // see RL11
            op_fetch_reg <= 1'b0;
            if (eff_sim_stor) begin
              state_reg <= ST_DONE;
            end else begin
              state_reg <= ST_STORE;
              stor_req  <= '{req: 1'b1, write: 1'b1, data: panel_byte_switches};  // see RL11
            end
          end else if (!chan_halt && (man_fetch || fetch_req)) begin
            op_fetch_reg <= 1'b1;
            if (eff_sim_stor) begin
              a_reg     <= panel_byte_switches;            // see RL12
              state_reg <= ST_DONE;
            end else begin
              state_reg <= ST_FETCH;
              stor_req  <= '{req: 1'b1, write: 1'b0, data: 8'h00};
            end
          end
        end
        ST_STORE: begin
          if (stor_rsp.ack) begin
            stor_req  <= '0;
            state_reg <= ST_DONE;
          end
        end
        ST_FETCH: begin
          if (stor_rsp.ack) begin
            a_reg     <= stor_rsp.data;                    // see RL12
            stor_req  <= '0;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          fetch_data <= '{valid: op_fetch_reg, data: a_reg};
          state_reg  <= ST_IDLE;
        end
        default: begin
          stor_req  <= '0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // events, status, interrupt
  // ----------------------------------------------------------------
  assign ev[EV_STORE]  = (state_reg == ST_DONE) && !op_fetch_reg;
  assign ev[EV_FETCH]  = (state_reg == ST_DONE) && op_fetch_reg;
  assign ev[EV_LOGOUT] = logout_next;
  assign ev[EV_HALT]   = halt_set;
  assign ev[EV_SIMWR]  = sir_loaded;
  // a new event beats a simultaneous clear
  assign status_next   = (status_reg & ~w1c) | ev;

  // halt stays until software clears its status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
      chan_halt  <= 1'b0;
      irq        <= 1'b0;
    end else if (clr) begin
      status_reg <= '0;
      chan_halt  <= 1'b0;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      chan_halt  <= status_next[EV_HALT];                  // see RL8
      irq        <= |(status_next & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // simulated interface and lamps
  // ----------------------------------------------------------------
  spt_sim_iface u_sim (
    .pclk       (pclk),
    .presetn    (presetn),
    .clr        (clr),
    .sim_en     (eff_sim_iface),
    .chan_io    (chan_io),
    .io_in      (io_in),
    .line_out   (io_out),
    .bus_in     (bus_in),
    .sir        (sir),
    .sir_loaded (sir_loaded)
  );

  spt_lamp_drv u_lamps (
    .pclk      (pclk),
    .presetn   (presetn),
    .lamp_test (ctrl_reg.lamp_check_switch),
    .a_byte    (a_reg),
    .b_byte    (bus_in.data),
    .status    (status_reg),
    .ctrl      (ctrl_reg),
    .state     (state_reg),
    .lamps     (lamps)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_logout;
    @(posedge pclk) disable iff (!presetn)
    (!clr && !test && ctrl_reg.logout_on_fault_switch && mach_chk) |=> logout_start;
  endproperty
  a_logout: assert property (p_logout) else $error("logout not started on machine check"); // see RL3

  property p_no_logout_test;
    @(posedge pclk) disable iff (!presetn)
    test |=> !logout_start;
  endproperty
  a_no_logout_test: assert property (p_no_logout_test) else $error("logout raised in test mode"); // see RL7

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
    (!clr && test && ctrl_reg.logout_on_fault_switch && (mach_chk || data_chk)) |=> chan_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("channel did not halt on check"); // see RL8

  property p_auto_cmd;
    @(posedge pclk) disable iff (!presetn)
    (!clr && !test) |=> (chan_cmd == $past(cpu_cmd));
  endproperty
  a_auto_cmd: assert property (p_auto_cmd) else $error("processor command not passed on line"); // see RL1

  property p_test_offline;
    @(posedge pclk) disable iff (!presetn)
    (test && !cmd_wr) |=> (chan_cmd == '0);
  endproperty
  a_test_offline: assert property (p_test_offline) else $error("processor command leaked off line"); // see RL5

  property p_block;
    @(posedge pclk) disable iff (!presetn)
    (!clr) |=> (stor_block == $past(eff_sim_stor)) && (io_block == $past(eff_sim_iface));
  endproperty
  a_block: assert property (p_block) else $error("interface blocking wrong"); // see RL9

  property p_sim_no_mem;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_IDLE && eff_sim_stor && !chan_halt && (man_store || man_fetch)) |=> !stor_req.req ##1 !stor_req.req;
  endproperty
  a_sim_no_mem: assert property (p_sim_no_mem) else $error("storage touched under simulation"); // see RL11

  property p_sim_fetch;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_IDLE && eff_sim_stor && !chan_halt && !man_store && (man_fetch || fetch_req))
      |=> ##1 (fetch_data.valid && fetch_data.data == $past(panel_byte_switches, 2));
  endproperty
  a_sim_fetch: assert property (p_sim_fetch) else $error("simulated fetch not from panel byte"); // see RL12

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (!clr && |(status_next & mask_reg)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing for unmasked status");

endmodule
`default_nettype wire

// file: sim/spt_stor_model.sv
// behavioural main-storage model answering the channel storage requests
`timescale 1ns/1ns
`default_nettype none
module spt_stor_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire spt_pkg::spt_stor_req_type stor_req,
  output var  spt_pkg::spt_stor_rsp_type stor_rsp,
  output var  logic [7:0]                mem_reg
);
  import spt_pkg::*;
  logic [3:0] wait_reg;
  // slow answer after a few cycles; data toggles when idle so a stale byte is never trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stor_rsp <= '0;
      wait_reg <= 4'h0;
      mem_reg  <= 8'hc3;
    end else if (stor_req.req && !stor_rsp.ack && wait_reg == 4'h3) begin
      stor_rsp <= {1'b1, mem_reg};
      wait_reg <= 4'h0;
      if (stor_req.write) mem_reg <= stor_req.data;
    end else begin
      stor_rsp <= {1'b0, ~stor_rsp.data};
      wait_reg <= (stor_req.req && !stor_rsp.ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_service_panel_test_control.sv
// self-checking bench for the service panel test control
`timescale 1ns/1ns
`default_nettype none
module test_service_panel_test_control;
  import spt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, power_complete = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rdat;
  spt_chio_type chan_io = '0;
  spt_stor_req_type stor_req;
  spt_stor_rsp_type stor_rsp;
  spt_byte_type bus_in, fetch_data;
  logic [31:0] prdata;
  logic pready, pslverr, stor_block, io_block, irq;
  logic [7:0] mem;
  logic mach_chk = 0, data_chk = 0, rerr, chan_halt, logout_start;
  spt_lamp_type lamps;
  int failures = 0, checked = 0, cyc = 0;
  logic [6:0] rows [4] = '{{5'h18, 2'b00}, {5'h09, 2'b10}, {5'h11, 2'b01}, {5'h01, 2'b00}};
  always #2 pclk = ~pclk;
  spt_service_panel dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_complete(power_complete), .mach_chk(mach_chk), .data_chk(data_chk), .cpu_cmd('0), .fetch_req(1'b0),
    .stor_rsp(stor_rsp), .stor_req(stor_req), .stor_block(stor_block), .chan_io(chan_io), .io_in('0),
    .io_out(), .io_block(io_block), .bus_in(bus_in), .chan_cmd(), .fetch_data(fetch_data),
    .logout_start(logout_start), .chan_halt(chan_halt), .lamps(lamps), .irq(irq));
  spt_stor_model m (.pclk(pclk), .presetn(presetn), .stor_req(stor_req), .stor_rsp(stor_rsp), .mem_reg(mem));
  task automatic complete_run;
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer; pready, data and error taken at the rising edge that ends it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  always @(posedge pclk) if (++cyc == 4000) begin failures++; complete_run; end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(irq, 1'b0);
    chk(stor_block, 1'b0);
    @(posedge pclk) power_complete <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, OFF_CTRL, 0); chk(rdat, 32'h0);
    // mode and simulation selections against the two blocking outputs
    foreach (rows[i]) begin
      apb(1, OFF_CTRL, rows[i][6:2]);
      repeat (3) @(negedge pclk);
      chk({stor_block, io_block}, rows[i][1:0]);
    end
    // manual store to real storage through the slow model
    apb(1, OFF_PANEL, 32'h77); apb(1, OFF_CMD, 32'h10);
    repeat (12) @(posedge pclk);
    apb(0, OFF_STAT, 0); chk(rdat[0], 1'b1); chk(mem, 8'h77);
    // simulated fetch returns the panel byte
    apb(1, OFF_CTRL, 32'h09); apb(1, OFF_PANEL, 32'h5a); apb(1, OFF_CMD, 32'h20);
    for (int i = 0; i < 20 && fetch_data.valid !== 1'b1; i++) @(negedge pclk);
    chk(fetch_data, {1'b1, 8'h5a});
    // simulated write byte kept, read back, raises and clears the interrupt
    apb(1, OFF_CTRL, 32'h11); apb(1, OFF_MASK, 32'h10);
    @(posedge pclk) chan_io <= {3'b010, 8'h3c};
    @(posedge pclk) chan_io <= {3'b001, 8'h00};
    @(posedge pclk) chan_io <= '0;
    repeat (4) @(negedge pclk);
    chk(irq, 1'b1);
    apb(0, OFF_INFO, 0); chk(rdat[23:16], 8'h3c);
    apb(1, OFF_STAT, 32'h10); repeat (2) @(negedge pclk); chk(irq, 1'b0);
    @(posedge pclk) chan_io <= {3'b001, 8'h00};
    @(posedge pclk) chan_io <= '0;
    @(negedge pclk) chk(bus_in, {1'b1, 8'h3c});
    // logout in automatic mode, then halt on data check in test mode
    apb(1, OFF_CTRL, 32'h04); @(posedge pclk) mach_chk <= 1'b1;
    @(posedge pclk) mach_chk <= 1'b0;
    @(negedge pclk) chk(logout_start, 1'b1);
    apb(1, OFF_CTRL, 32'h05); apb(1, OFF_PANEL, 32'h66);
    @(posedge pclk) data_chk <= 1'b1;
    @(posedge pclk) data_chk <= 1'b0;
    @(negedge pclk) chk(chan_halt, 1'b1);
    apb(1, OFF_CMD, 32'h10); repeat (12) @(posedge pclk);
    chk(mem, 8'h77);
    // lamp check forces parity and status lamps on
    apb(1, OFF_CTRL, 32'h02); repeat (2) @(negedge pclk);
    chk({lamps.a_lamps[8], lamps.b_lamps[8], lamps.status_lamps}, 7'h7f);
    apb(0, 12'h0f0, 0); chk(rerr, 1'b1); chk(rdat, 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
